// *** hdl/adc_powerdown_conversion_ctrl.sv ***
// Power-down, conversion start and parallel read control of the converter.
`timescale 1ns/1ns
`include "adc_ctrl_defines.svh"

// Function
// - Low request, high range: enter standby.
// - Power-down entry acts at once, mid conversion.
// - Standby: front ends off, reference stays on.
// - Request high leaves standby; 100 us settle.
// - Low request, low range: full shutdown.
// - Tied triggers sample all channels together.
// - Busy rises at start, bounded conversion time.
// - Busy falls, result registers update together.
// - Each read edge presents next channel, or next byte in byte mode.
// - All six channels always converted and read.
// - First-channel flag high on reads of channel one.
// - Chip select high tri-states bus and flag.
// - Trigger A holds channels one to three.
// - Trigger B holds channels four to six.
// - Conversion starts once both groups held.
// - Reads during busy give previous results.
// - Two mode pins pick read interface.
module adc_powerdown_conversion_ctrl #(
	parameter int NUM_CH = `NUM_CHANNELS,
	parameter int FIFO_DEPTH = `FIFO_DEPTH,
	parameter int CONV_CYCLES = `MAX_CONV_CYCLES,
	parameter int SHUTDOWN_SETTLE_CYCLES = `SHUTDOWN_SETTLE_CYCLES
) (
	input wire sys_clk,
	input wire reset,
	input wire power_down_request_n,
	input wire range_select,
	input wire sample_trigger_group_a,
	input wire sample_trigger_group_b,
	input adc_ctrl_pkg::sample_t [NUM_CH-1:0] channel_level_in,
	input wire cs_n,
	input wire rd_n,
	input wire interface_select_primary,
	input wire interface_select_secondary,
	input wire byte_order_msb_first,
	output logic busy,
	output logic frontend_power_on,
	output logic reference_power_on,
	output logic power_ready,
	output logic reset_required,
	output logic [15:0] parallel_result_bus,
	output logic parallel_result_bus_oe_n,
	output logic first_channel_flag,
	output logic first_channel_flag_oe_n
);
	import adc_ctrl_pkg::*;

	if (NUM_CH != 2 * `GROUP_SIZE || FIFO_DEPTH < NUM_CH ||
			CONV_CYCLES < NUM_CH + 2 || SHUTDOWN_SETTLE_CYCLES < 1 ||
			SHUTDOWN_SETTLE_CYCLES > (1 << `SETTLE_CNT_WIDTH))
	begin : g_bad_param
		$error("adc_powerdown_conversion_ctrl: unsupported parameters");
	end

	localparam int GROUP = `GROUP_SIZE;
	localparam logic [17:0] STANDBY_TARGET =
		18'(`STANDBY_SETTLE_CYCLES - 1);
	localparam logic [17:0] SHUTDOWN_TARGET =
		18'(SHUTDOWN_SETTLE_CYCLES - 1);
	localparam logic [2:0] PUSH_LAST = 3'(NUM_CH - 1);
	localparam logic [3:0] PAR_LAST = 4'(NUM_CH - 1);
	localparam logic [3:0] BYTE_LAST = 4'(2 * NUM_CH - 1);

	pwr_state_t pwr_state_reg;
	pwr_state_t pwr_state_next;
	logic shutdown_reg;
	logic [17:0] settle_cnt_reg;
	logic [17:0] settle_target;
	logic trig_a_prev_reg;
	logic trig_b_prev_reg;
	logic a_rise;
	logic b_rise;
	logic held_a_reg;
	logic held_b_reg;
	sample_t [NUM_CH-1:0] hold_reg;
	logic busy_reg;
	logic trigger_enable;
	logic start_conv;
	logic abort;
	logic push_active_reg;
	logic [2:0] push_idx_reg;
	sample_t [NUM_CH-1:0] results_reg;
	sample_t [NUM_CH-1:0] conv_results;
	logic conv_done;
	if_mode_t if_mode;
	logic rd_prev_reg;
	logic read_fall;
	logic [3:0] read_idx_reg;
	logic [3:0] read_last;
	logic [15:0] bus_data_reg;
	logic flag_reg;
	sample_t current_word;
	sample_t byte_word;
	logic take_msb;
	logic [15:0] busy_cnt_reg;

	sample_stream_if #(.W(`SAMPLE_WIDTH)) push_s ();
	sample_stream_if #(.W(`SAMPLE_WIDTH)) pop_s ();

	// A low request aborts everything in the same cycle it is seen.
	assign abort = !power_down_request_n;
	assign settle_target = shutdown_reg ? SHUTDOWN_TARGET : STANDBY_TARGET;

	always_comb begin
		pwr_state_next = pwr_state_reg;
		unique case (pwr_state_reg)
			PWR_ACTIVE: begin
				if (!power_down_request_n) begin
					pwr_state_next = PWR_DOWN;
				end
			end
			PWR_DOWN: begin
				if (power_down_request_n) begin
					pwr_state_next = PWR_SETTLE;
				end
			end
			PWR_SETTLE: begin
				if (!power_down_request_n) begin
					pwr_state_next = PWR_DOWN;
				end else if (settle_cnt_reg == settle_target) begin
					pwr_state_next = shutdown_reg ? PWR_NEED_RESET :
						PWR_ACTIVE;
				end
			end
			PWR_NEED_RESET: begin
				if (!power_down_request_n) begin
					pwr_state_next = PWR_DOWN;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pwr_state_reg <= PWR_ACTIVE;
		end else begin
			pwr_state_reg <= pwr_state_next;
		end
	end

	// The range pin picks the power-down depth while the request is low.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			shutdown_reg <= 1'b0;
		end else if (!power_down_request_n) begin
			shutdown_reg <= !range_select;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset || pwr_state_reg != PWR_SETTLE) begin
			settle_cnt_reg <= 18'h0_0000;
		end else begin
			settle_cnt_reg <= settle_cnt_reg + 18'h0_0001;
		end
	end

	// Front-end power drops with the request pin without waiting for a clock, reference power only with range low; they come back on after the next clock edge.
	assign frontend_power_on = power_down_request_n &&
		(pwr_state_reg != PWR_DOWN);
	assign reference_power_on = power_down_request_n ?
		!(pwr_state_reg == PWR_DOWN && shutdown_reg) :
		range_select;
	assign power_ready = power_down_request_n && (pwr_state_reg == PWR_ACTIVE);
	assign reset_required = (pwr_state_reg == PWR_NEED_RESET);

	assign a_rise = sample_trigger_group_a && !trig_a_prev_reg;
	assign b_rise = sample_trigger_group_b && !trig_b_prev_reg;
	assign start_conv = held_a_reg && held_b_reg && !busy_reg;
	assign trigger_enable = power_ready && !busy_reg && !start_conv &&
		!push_active_reg;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			trig_a_prev_reg <= 1'b0;
			trig_b_prev_reg <= 1'b0;
		end else begin
			trig_a_prev_reg <= sample_trigger_group_a;
			trig_b_prev_reg <= sample_trigger_group_b;
		end
	end

	// Tied triggers rise together, so both groups are held on one edge.
	always_ff @(posedge sys_clk) begin
		if (reset || abort) begin
			held_a_reg <= 1'b0;
			held_b_reg <= 1'b0;
		end else if (start_conv) begin
			held_a_reg <= 1'b0;
			held_b_reg <= 1'b0;
		end else begin
			if (a_rise && trigger_enable && !held_a_reg) begin
				held_a_reg <= 1'b1;
			end
			if (b_rise && trigger_enable && !held_b_reg) begin
				held_b_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			hold_reg <= '0;
		end else begin
			for (int i = 0; i < GROUP; i++) begin
				if (a_rise && trigger_enable && !held_a_reg) begin
					hold_reg[i] <= channel_level_in[i];
				end
				if (b_rise && trigger_enable && !held_b_reg) begin
					hold_reg[i + GROUP] <=
						channel_level_in[i + GROUP];
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset || abort) begin
			busy_reg <= 1'b0;
		end else if (start_conv) begin
			busy_reg <= 1'b1;
		end else if (conv_done) begin
			busy_reg <= 1'b0;
		end
	end

	assign busy = busy_reg;

	// Every held channel is queued, used or not.
	always_ff @(posedge sys_clk) begin
		if (reset || abort) begin
			push_active_reg <= 1'b0;
			push_idx_reg <= 3'h0;
		end else if (start_conv) begin
			push_active_reg <= 1'b1;
			push_idx_reg <= 3'h0;
		end else if (push_active_reg && push_s.ready) begin
			push_active_reg <= (push_idx_reg != PUSH_LAST);
			push_idx_reg <= push_idx_reg + 3'h1;
		end
	end

	assign push_s.valid = push_active_reg;
	assign push_s.data = hold_reg[push_idx_reg];

	result_fifo #(.WIDTH(`SAMPLE_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk(sys_clk),
		.reset(reset),
		.flush(abort),
		.in_s(push_s),
		.out_s(pop_s)
	);

	conv_engine #(.NUM_CH(NUM_CH), .CONV_CYCLES(CONV_CYCLES)) u_conv (
		.sys_clk(sys_clk),
		.reset(reset),
		.start(start_conv),
		.abort(abort),
		.in_s(pop_s),
		.done(conv_done),
		.results(conv_results)
	);

	// Results change only at the end of a conversion.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			results_reg <= '0;
		end else if (conv_done && !abort) begin
			results_reg <= conv_results;
		end
	end

	assign if_mode = decode_if_mode(interface_select_primary,
		interface_select_secondary);
	assign read_fall = rd_prev_reg && !rd_n && !cs_n &&
		(if_mode != IF_SERIAL);
	assign read_last = (if_mode == IF_BYTE) ? BYTE_LAST : PAR_LAST;
	assign current_word = results_reg[read_idx_reg[2:0]];
	assign byte_word = results_reg[read_idx_reg[3:1]];
	assign take_msb = read_idx_reg[0] ^ byte_order_msb_first;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rd_prev_reg <= 1'b1;
		end else begin
			rd_prev_reg <= rd_n;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset || (conv_done && !abort)) begin
			read_idx_reg <= 4'h0;
		end else if (read_fall) begin
			read_idx_reg <= (read_idx_reg >= read_last) ? 4'h0 :
				read_idx_reg + 4'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			bus_data_reg <= `RESULT_RESET;
			flag_reg <= 1'b0;
		end else if (read_fall) begin
			if (if_mode == IF_BYTE) begin
				bus_data_reg <= {8'h00, take_msb ? byte_word[15:8] :
					byte_word[7:0]};
				flag_reg <= (read_idx_reg < 4'h2);
			end else begin
				bus_data_reg <= current_word;
				flag_reg <= (read_idx_reg == 4'h0);
			end
		end
	end

	assign parallel_result_bus = bus_data_reg;
	assign first_channel_flag = flag_reg;
	assign parallel_result_bus_oe_n = reset || cs_n ||
		(if_mode == IF_SERIAL);
	assign first_channel_flag_oe_n = parallel_result_bus_oe_n;

	always_ff @(posedge sys_clk) begin
		if (reset || !busy_reg) begin
			busy_cnt_reg <= 16'h0000;
		end else begin
			busy_cnt_reg <= busy_cnt_reg + 16'h0001;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	property p_standby;
		(!power_down_request_n && range_select) |->
			(!frontend_power_on && reference_power_on);
	endproperty
	a_standby: assert property (p_standby)
		else $error("standby power controls wrong");

	property p_shutdown;
		(!power_down_request_n && !range_select) |->
			(!frontend_power_on && !reference_power_on);
	endproperty
	a_shutdown: assert property (p_shutdown)
		else $error("shutdown did not power everything off");

	property p_abort;
		!power_down_request_n |=> (!busy_reg && pwr_state_reg == PWR_DOWN);
	endproperty
	a_abort: assert property (p_abort)
		else $error("power-down did not abort");

	property p_settle;
		($rose(power_down_request_n) && pwr_state_reg == PWR_DOWN) |=>
			!trigger_enable [*8];
	endproperty
	a_settle: assert property (p_settle)
		else $error("triggers accepted during settling");

	property p_need_reset;
		(pwr_state_reg == PWR_NEED_RESET) |-> (!trigger_enable && !busy_reg);
	endproperty
	a_need_reset: assert property (p_need_reset)
		else $error("conversion possible before reset");

	property p_busy_len;
		busy_cnt_reg <= 16'(CONV_CYCLES);
	endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("busy exceeded conversion time");

	property p_update;
		(conv_done && !abort) |=>
			(!busy_reg && results_reg == $past(conv_results));
	endproperty
	a_update: assert property (p_update)
		else $error("results not updated as busy fell");

	property p_start;
		$rose(busy_reg) |-> $past(held_a_reg && held_b_reg);
	endproperty
	a_start: assert property (p_start)
		else $error("conversion started without both groups");

	property p_group_a;
		(a_rise && trigger_enable && !held_a_reg) |=>
			(held_a_reg && hold_reg[0] == $past(channel_level_in[0]));
	endproperty
	a_group_a: assert property (p_group_a)
		else $error("group A not held");

	property p_ignore;
		(busy_reg && a_rise) |=> !held_a_reg;
	endproperty
	a_ignore: assert property (p_ignore)
		else $error("trigger accepted while busy");

	property p_prev;
		(busy_reg && !conv_done) |=> $stable(results_reg);
	endproperty
	a_prev: assert property (p_prev)
		else $error("results changed during conversion");

	property p_order;
		(read_fall && if_mode == IF_PARALLEL) |=>
			(parallel_result_bus == $past(current_word) &&
			first_channel_flag == ($past(read_idx_reg) == 4'h0));
	endproperty
	a_order: assert property (p_order)
		else $error("wrong channel or flag on read");

	property p_tristate;
		cs_n |-> (parallel_result_bus_oe_n && first_channel_flag_oe_n);
	endproperty
	a_tristate: assert property (p_tristate)
		else $error("bus driven outside a frame");

	property p_mode;
		(interface_select_primary && !interface_select_secondary) |->
			(if_mode == IF_SERIAL && parallel_result_bus_oe_n);
	endproperty
	a_mode: assert property (p_mode)
		else $error("serial select did not release bus");

	c_shared: cover property (a_rise && b_rise && trigger_enable);
	c_split: cover property (held_a_reg && !held_b_reg ##[1:20] start_conv);
	c_done: cover property (conv_done ##[1:50] read_fall);
	c_wake: cover property (pwr_state_reg == PWR_SETTLE ##1
		pwr_state_reg == PWR_ACTIVE);

endmodule : adc_powerdown_conversion_ctrl

// *** hdl/adc_ctrl_defines.svh ***
// Widths, timing figures and counts for the converter control block.
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

`define CLK_PERIOD_NS 100
`define STANDBY_SETTLE_US 100
`define STANDBY_SETTLE_CYCLES \
	((`STANDBY_SETTLE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SHUTDOWN_SETTLE_MS 13
`define SHUTDOWN_SETTLE_CYCLES \
	((`SHUTDOWN_SETTLE_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MAX_CONV_TIME_NS 4000
`define MAX_CONV_CYCLES (`MAX_CONV_TIME_NS / `CLK_PERIOD_NS)
`define NUM_CHANNELS 6
`define GROUP_SIZE 3
`define SAMPLE_WIDTH 16
`define FIFO_DEPTH 16
`define SETTLE_CNT_WIDTH 18
`define RESULT_RESET 16'h0000

`endif

// *** hdl/adc_ctrl_pkg.sv ***
// Types and decode helpers shared by the converter control modules.
`include "adc_ctrl_defines.svh"

package adc_ctrl_pkg;

	typedef logic [`SAMPLE_WIDTH-1:0] sample_t;

	typedef enum logic [1:0] {
		PWR_ACTIVE = 2'h0,
		PWR_DOWN = 2'h1,
		PWR_SETTLE = 2'h3,
		PWR_NEED_RESET = 2'h2
	} pwr_state_t;

	typedef enum logic [1:0] {
		IF_PARALLEL = 2'h0,
		IF_SERIAL = 2'h1,
		IF_BYTE = 2'h2
	} if_mode_t;

	function automatic if_mode_t decode_if_mode(input logic primary,
			input logic secondary);
		if (!primary) begin
			return IF_PARALLEL;
		end
		return secondary ? IF_BYTE : IF_SERIAL;
	endfunction : decode_if_mode

endpackage : adc_ctrl_pkg

// *** hdl/sample_stream_if.sv ***
// Valid/ready stream of held samples between the control modules.
`timescale 1ns/1ns

interface sample_stream_if #(parameter int W = 16);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface : sample_stream_if

// *** hdl/result_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides and a flush input.
`timescale 1ns/1ns

module result_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire sys_clk,
	input wire reset,
	input wire flush,
	sample_stream_if.snk in_s,
	sample_stream_if.src out_s
);
	import adc_ctrl_pkg::*;

	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
		$error("result_fifo: DEPTH must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] rd_ptr_reg;
	logic full;
	logic empty;
	logic push;
	logic pop;

	assign empty = (wr_ptr_reg == rd_ptr_reg);
	assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
		(wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
	assign in_s.ready = !full;
	assign out_s.valid = !empty;
	assign out_s.data = mem[rd_ptr_reg[AW-1:0]];
	assign push = in_s.valid && !full;
	assign pop = out_s.ready && !empty;

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr_reg[AW-1:0]] <= in_s.data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset || flush) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end

endmodule : result_fifo

// *** hdl/conv_engine.sv ***
// Conversion timer that drains held samples and reports the finished set.
`timescale 1ns/1ns

module conv_engine #(
	parameter int NUM_CH = 6,
	parameter int CONV_CYCLES = 40
) (
	input wire sys_clk,
	input wire reset,
	input wire start,
	input wire abort,
	sample_stream_if.snk in_s,
	output logic done,
	output adc_ctrl_pkg::sample_t [NUM_CH-1:0] results
);
	import adc_ctrl_pkg::*;

	if (CONV_CYCLES < NUM_CH + 2 || CONV_CYCLES > 65535 || NUM_CH > 8)
	begin : g_bad_param
		$error("conv_engine: conversion time too short for the channels");
	end

	localparam logic [15:0] LAST_CYCLE = 16'(CONV_CYCLES - 1);
	localparam logic [3:0] ALL_CH = 4'(NUM_CH);

	logic active_reg;
	logic [15:0] cnt_reg;
	logic [3:0] got_reg;

	assign in_s.ready = active_reg && (got_reg < ALL_CH);
	assign done = active_reg && (cnt_reg == LAST_CYCLE) && (got_reg == ALL_CH);

	always_ff @(posedge sys_clk) begin
		if (reset || abort) begin
			active_reg <= 1'b0;
		end else if (start) begin
			active_reg <= 1'b1;
		end else if (done) begin
			active_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset || start) begin
			cnt_reg <= 16'h0000;
		end else if (active_reg && cnt_reg != LAST_CYCLE) begin
			cnt_reg <= cnt_reg + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset || start) begin
			got_reg <= 4'h0;
		end else if (in_s.valid && in_s.ready) begin
			got_reg <= got_reg + 4'h1;
		end
	end

	// The front end already delivers quantised levels, so a word is kept as is.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			results <= '0;
		end else if (in_s.valid && in_s.ready) begin
			results[got_reg[2:0]] <= in_s.data;
		end
	end

endmodule : conv_engine

// *** tb/host_model.sv ***
// Host controller model that drives the triggers, levels and read strobes.
`timescale 1ns/1ns

module host_model (
	input wire sys_clk,
	input wire busy,
	input wire [15:0] bus,
	input wire flag,
	input wire oe_n,
	output logic trig_a,
	output logic trig_b,
	output logic cs_n,
	output logic rd_n,
	output adc_ctrl_pkg::sample_t [5:0] lvl
);
	import adc_ctrl_pkg::*;

	initial begin
		trig_a = 1'b0;
		trig_b = 1'b0;
		cs_n = 1'b1;
		rd_n = 1'b1;
		lvl = '0;
	end

	// Levels move right after the first hold so that late capture shows.
	task automatic convert(input logic split, input sample_t base,
			output logic early);
		early = 1'b0;
		@(posedge sys_clk);
		for (int i = 0; i < 6; i++) begin
			lvl[i] <= base + 16'(i);
		end
		trig_a <= 1'b1;
		trig_b <= !split;
		@(posedge sys_clk);
		for (int i = 0; i < 6; i++) begin
			lvl[i] <= base + 16'h0100 + 16'(i);
		end
		if (split) begin
			@(posedge sys_clk);
			#1 early = busy;
			@(posedge sys_clk);
			trig_b <= 1'b1;
			@(posedge sys_clk);
		end
		trig_a <= 1'b0;
		trig_b <= 1'b0;
	endtask : convert

	// Tied select and strobe, released after every word.
	task automatic read(output sample_t d, output logic f, output logic oe);
		@(posedge sys_clk);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1 d = bus;
		f = flag;
		oe = oe_n;
		@(posedge sys_clk);
		cs_n <= 1'b1;
		rd_n <= 1'b1;
	endtask : read
endmodule : host_model

// *** tb/test_adc_powerdown_conversion_ctrl.sv ***
// Self-checking bench for the converter power-down and conversion control.
`timescale 1ns/1ns

module test_adc_powerdown_conversion_ctrl;
	import adc_ctrl_pkg::*;
	typedef struct packed {logic split; sample_t base;} row_t;
	localparam logic [15:0] CONV = 16'h0008;
	row_t rows [3] = '{'{1'b0, 16'h1000}, '{1'b1, 16'h2000},
		'{1'b0, 16'hfff0}};
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic pd_n = 1'b1;
	logic rng = 1'b1;
	logic psel = 1'b0;
	logic ssel = 1'b0;
	logic msb_first = 1'b1;
	logic ta, tb_b, cs_n, rd_n, busy, fe_on, ref_on, p_rdy, rst_req;
	logic bus_oe_n, flag, flag_oe_n, early, f, oe;
	logic [15:0] bus;
	sample_t [5:0] lvl;
	sample_t d, ch;
	int fail_count = 0;
	int n_tests = 0;
	int n, cnt;

	always #50 sys_clk = ~sys_clk;

	adc_powerdown_conversion_ctrl #(.CONV_CYCLES(8),
		.SHUTDOWN_SETTLE_CYCLES(20)) dut (.sys_clk(sys_clk), .reset(reset),
		.power_down_request_n(pd_n), .range_select(rng),
		.sample_trigger_group_a(ta), .sample_trigger_group_b(tb_b),
		.channel_level_in(lvl), .cs_n(cs_n), .rd_n(rd_n),
		.interface_select_primary(psel), .interface_select_secondary(ssel),
		.byte_order_msb_first(msb_first), .busy(busy),
		.frontend_power_on(fe_on), .reference_power_on(ref_on),
		.power_ready(p_rdy), .reset_required(rst_req),
		.parallel_result_bus(bus), .parallel_result_bus_oe_n(bus_oe_n),
		.first_channel_flag(flag), .first_channel_flag_oe_n(flag_oe_n));

	host_model host (.sys_clk(sys_clk), .busy(busy), .bus(bus), .flag(flag),
		.oe_n(bus_oe_n), .trig_a(ta), .trig_b(tb_b), .cs_n(cs_n),
		.rd_n(rd_n), .lvl(lvl));

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : wrap_up

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic too_long();
		fail_count++;
		wrap_up();
	endtask : too_long

	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask : tick

	// Counts the cycles that busy stays high once it has risen.
	task automatic busy_len(output int len);
		int t;
		t = 0;
		len = 0;
		while (busy !== 1'b1) begin
			tick();
			t++;
			if (t > 20) too_long();
		end
		while (busy === 1'b1) begin
			tick();
			len++;
			if (len > 100) too_long();
		end
	endtask : busy_len

	task automatic rd_chk(input sample_t e, input logic ef);
		host.read(d, f, oe);
		check(d, e);
		check(16'(f), 16'(ef));
		check(16'(oe), 16'h0000);
	endtask : rd_chk

	function automatic sample_t expv(input row_t r, input int c);
		return (r.split && c > 2) ? r.base + 16'h0100 + 16'(c) :
			r.base + 16'(c);
	endfunction : expv

	task automatic wait_for(ref logic s, input int lim, output int c);
		c = 0;
		while (s !== 1'b1) begin
			tick();
			c++;
			if (c > lim) too_long();
		end
	endtask : wait_for

	initial begin
		repeat (4) @(posedge sys_clk);
		#1 check(16'(bus_oe_n), 16'h0001);
		check(16'(busy), 16'h0000);
		@(posedge sys_clk);
		reset <= 1'b0;
		for (int r = 0; r < 3; r++) begin
			host.convert(rows[r].split, rows[r].base, early);
			check(16'(early), 16'h0000);
			busy_len(n);
			check(n[15:0], CONV);
			for (int k = 0; k < 7; k++) begin
				rd_chk(expv(rows[r], k % 6), k % 6 == 0);
			end
			tick();
			check(16'(bus_oe_n), 16'h0001);
			check(16'(flag_oe_n), 16'h0001);
			$display("row %0d done", r);
		end
		host.convert(1'b0, 16'h3000, early);
		rd_chk(16'hfff1, 1'b0);
		host.convert(1'b0, 16'h4000, early);
		busy_len(n);
		rd_chk(16'h3000, 1'b1);
		check(16'(busy), 16'h0000);
		$display("busy read test done");
		@(posedge sys_clk);
		psel <= 1'b1;
		ssel <= 1'b1;
		host.convert(1'b0, 16'h5a00, early);
		busy_len(n);
		for (int k = 0; k < 12; k++) begin
			ch = 16'h5a00 + 16'(k / 2);
			rd_chk({8'h00, (k % 2 == 0) ? ch[15:8] : ch[7:0]}, k < 2);
		end
		// Low byte first: channel 1 again after the wrap, flag high twice.
		@(posedge sys_clk);
		msb_first <= 1'b0;
		rd_chk(16'h0000, 1'b1);
		rd_chk(16'h005a, 1'b1);
		@(posedge sys_clk);
		ssel <= 1'b0;
		host.read(d, f, oe);
		check(16'(oe), 16'h0001);
		@(posedge sys_clk);
		psel <= 1'b0;
		$display("mode test done");
		host.convert(1'b0, 16'h6000, early);
		@(posedge sys_clk);
		pd_n <= 1'b0;
		#1 check(16'(fe_on), 16'h0000);
		check(16'(ref_on), 16'h0001);
		tick();
		check(16'(busy), 16'h0000);
		host.convert(1'b0, 16'h7000, early);
		repeat (3) tick();
		check(16'(busy), 16'h0000);
		@(posedge sys_clk);
		pd_n <= 1'b1;
		wait_for(p_rdy, 1100, cnt);
		check(16'(cnt >= 1000), 16'h0001);
		$display("standby test done");
		@(posedge sys_clk);
		pd_n <= 1'b0;
		rng <= 1'b0;
		#1 check(16'(ref_on), 16'h0000);
		check(16'(fe_on), 16'h0000);
		@(posedge sys_clk);
		pd_n <= 1'b1;
		wait_for(rst_req, 100, cnt);
		check(16'(cnt >= 20), 16'h0001);
		host.convert(1'b0, 16'h7100, early);
		repeat (3) tick();
		check(16'(busy), 16'h0000);
		@(posedge sys_clk);
		reset <= 1'b1;
		@(posedge sys_clk);
		reset <= 1'b0;
		tick();
		check(16'(rst_req), 16'h0000);
		check(16'(p_rdy), 16'h0001);
		host.convert(1'b0, 16'h7700, early);
		busy_len(n);
		check(n[15:0], CONV);
		rd_chk(16'h7700, 1'b1);
		$display("shutdown test done");
		wrap_up();
	end
endmodule : test_adc_powerdown_conversion_ctrl
